// >>> src/amr_pkg.sv
// Constants and types shared by the mode register bank and its serial port.
// Assumes a single 50 MHz core clock; all serial pins are asynchronous to it.
package amr_pkg;

	// ----------------------------------------------------------------
	// Serial frame layout
	// ----------------------------------------------------------------
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] HDR_LAST = 5'h07;
	localparam logic [CNT_W-1:0] FRAME_LAST = 5'h0f;
	localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
	localparam logic [3:0] RD_BITS = 4'h8;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_SOFT_RESET = 7'h00;
	localparam logic [ADDR_W-1:0] ADDR_FMT_PWR = 7'h01;
	localparam logic [DATA_W-1:0] FMT_PWR_RESET = 8'h00;
	localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
	localparam int SOFT_RESET_BIT = 7;
	localparam int STAB_DIS_BIT = 7;
	localparam int SCRAMBLE_BIT = 6;
	localparam int SIGNED_BIT = 5;
	localparam int SLEEP_BIT = 4;
	localparam int NAP_LSB = 0;

	// ----------------------------------------------------------------
	// Channels and sample words
	// ----------------------------------------------------------------
	localparam int NUM_CH = 4;
	localparam int SAMPLE_W = 14;
	typedef logic [SAMPLE_W-1:0] amr_sample_t;
	typedef amr_sample_t [NUM_CH-1:0] amr_chan_words_t;

	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_RESET = 2'b10
	} amr_state_t;

endpackage

// >>> src/amr_frame_if.sv
// Decoded serial frame events passed from the serial port to the registers.
// Assumes both ends run on the same core clock; every strobe is one cycle.
`timescale 1ns/1ps
interface amr_frame_if;
	logic hdr_stb;
	logic wr_stb;
	logic end_stb;
	logic fall_stb;
	logic rw;
	logic [6:0] addr;
	logic [7:0] data;

	modport port (
		output hdr_stb,
		output wr_stb,
		output end_stb,
		output fall_stb,
		output rw,
		output addr,
		output data
	);

	modport regs (
		input hdr_stb,
		input wr_stb,
		input end_stb,
		input fall_stb,
		input rw,
		input addr,
		input data
	);
endinterface

// >>> src/amr_spi_port.sv
// Serial port front end: synchronises the pins, counts clock edges, decodes frames.
// Assumes the serial clock is at least four core cycles per half period.
`timescale 1ns/1ps
module amr_spi_port (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic spi_cs_n_in,
	input wire logic spi_sck_in,
	input wire logic spi_sdi_in,
	amr_frame_if.port frm
);
	import amr_pkg::*;

	typedef struct packed {
		logic cs_n_m;
		logic cs_n_s;
		logic cs_n_p;
		logic sck_m;
		logic sck_s;
		logic sck_p;
		logic sdi_m;
		logic sdi_s;
		logic [CNT_W-1:0] cnt;
		logic [15:0] sh;
		logic hdr_stb;
		logic wr_stb;
		logic end_stb;
		logic fall_stb;
		logic rw;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} amr_port_state_t;

	localparam amr_port_state_t PORT_RESET = '{
		cs_n_m: 1'b1, cs_n_s: 1'b1, cs_n_p: 1'b1,
		sck_m: 1'b0, sck_s: 1'b0, sck_p: 1'b0,
		sdi_m: 1'b0, sdi_s: 1'b0,
		cnt: '0, sh: '0,
		hdr_stb: 1'b0, wr_stb: 1'b0, end_stb: 1'b0, fall_stb: 1'b0,
		rw: 1'b0, addr: '0, data: '0
	};

	amr_port_state_t q_r;
	amr_port_state_t q_nxt;

	always_comb begin
		logic [15:0] sh_v;
		sh_v = {q_r.sh[14:0], q_r.sdi_s};
		q_nxt = q_r;
		// Two-flop synchronisers; the second stage and, for chip select and clock, a third edge-detect flop feed logic
		q_nxt.cs_n_m = spi_cs_n_in;
		q_nxt.cs_n_s = q_r.cs_n_m;
		q_nxt.cs_n_p = q_r.cs_n_s;
		q_nxt.sck_m = spi_sck_in;
		q_nxt.sck_s = q_r.sck_m;
		q_nxt.sck_p = q_r.sck_s;
		q_nxt.sdi_m = spi_sdi_in;
		q_nxt.sdi_s = q_r.sdi_m;
		q_nxt.hdr_stb = 1'b0;
		q_nxt.wr_stb = 1'b0;
		q_nxt.end_stb = 1'b0;
		q_nxt.fall_stb = 1'b0;
		if (q_r.cs_n_s) begin
			q_nxt.cnt = '0;
			q_nxt.end_stb = ~q_r.cs_n_p;
		end else begin
			// Edges past the sixteenth are dropped here
			if (q_r.sck_s && !q_r.sck_p && (q_r.cnt < FRAME_BITS)) begin
				q_nxt.sh = sh_v;
				q_nxt.cnt = q_r.cnt + 5'h01;
				if (q_r.cnt == HDR_LAST) begin
					q_nxt.rw = sh_v[7];
					q_nxt.addr = sh_v[6:0];
					q_nxt.hdr_stb = 1'b1;
				end
				if (q_r.cnt == FRAME_LAST) begin
					q_nxt.data = sh_v[7:0];
					q_nxt.wr_stb = ~q_r.rw;
				end
			end
			q_nxt.fall_stb = ~q_r.sck_s & q_r.sck_p;
		end
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			q_r <= PORT_RESET;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign frm.hdr_stb = q_r.hdr_stb;
	assign frm.wr_stb = q_r.wr_stb;
	assign frm.end_stb = q_r.end_stb;
	assign frm.fall_stb = q_r.fall_stb;
	assign frm.rw = q_r.rw;
	assign frm.addr = q_r.addr;
	assign frm.data = q_r.data;

endmodule // amr_spi_port

// >>> src/amr_mode_regs.sv
// Mode register bank: software reset and format/power-down control of a quad converter.
// Assumes the serial host drives the pins directly and sample words arrive on the core clock.
`timescale 1ns/1ps

module amr_mode_regs (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic spi_cs_n_in,
	input wire logic spi_sck_in,
	input wire logic spi_sdi_in,
	output logic spi_sdo_out,
	output logic spi_sdo_oe_n_out,
	input wire amr_pkg::amr_chan_words_t conv_sample_in,
	output amr_pkg::amr_chan_words_t fmt_sample_out,
	output logic stabilizer_disable_out,
	output logic output_scramble_enable_out,
	output logic signed_format_select_out,
	output logic sleep_out,
	output logic [amr_pkg::NUM_CH-1:0] nap_out,
	output logic soft_reset_busy_out
);
	import amr_pkg::*;

	// ----------------------------------------------------------------
	// Serial port
	// ----------------------------------------------------------------
	amr_frame_if frm ();

	amr_spi_port u_port (
		.core_clk_in(core_clk_in),
		.resetn_in(resetn_in),
		.spi_cs_n_in(spi_cs_n_in),
		.spi_sck_in(spi_sck_in),
		.spi_sdi_in(spi_sdi_in),
		.frm(frm)
	);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		amr_state_t state;
		logic [DATA_W-1:0] fmt;
		logic [DATA_W-1:0] rd_sh;
		logic [3:0] rd_left;
		logic sdo_oe_n;
		logic sleep;
		logic [NUM_CH-1:0] nap;
		amr_chan_words_t samples;
	} amr_regs_state_t;

	localparam amr_regs_state_t REGS_RESET = '{
		state: ST_RUN,
		fmt: FMT_PWR_RESET,
		rd_sh: '0,
		rd_left: '0,
		sdo_oe_n: 1'b1,
		sleep: 1'b0,
		nap: '0,
		samples: '0
	};

	amr_regs_state_t q_r;
	amr_regs_state_t q_nxt;

	// ----------------------------------------------------------------
	// Output formatting per channel
	// ----------------------------------------------------------------
	amr_chan_words_t fmt_word;

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_fmt
			amr_sample_t signed_w;
			// Offset binary to two's complement is an MSB flip
			assign signed_w = {conv_sample_in[ch][SAMPLE_W-1] ^ q_r.fmt[SIGNED_BIT],
				conv_sample_in[ch][SAMPLE_W-2:0]};
			// LSB passes through unchanged so the far end can undo the xor
			assign fmt_word[ch] = {signed_w[SAMPLE_W-1:1] ^
				{(SAMPLE_W-1){signed_w[0] & q_r.fmt[SCRAMBLE_BIT]}},
				signed_w[0]};
		end
	endgenerate

	// ----------------------------------------------------------------
	// Register and readback logic
	// ----------------------------------------------------------------
	always_comb begin
		logic [DATA_W-1:0] rd_val;
		rd_val = READ_ZERO;
		if (frm.addr == ADDR_FMT_PWR) begin
			rd_val = q_r.fmt;
		end
		q_nxt = q_r;
		case (q_r.state)
			ST_RUN: begin
				if (frm.wr_stb && (frm.addr == ADDR_SOFT_RESET)) begin
					// Only the top bit acts
					if (frm.data[SOFT_RESET_BIT]) begin
						q_nxt.fmt = FMT_PWR_RESET;
						q_nxt.state = ST_RESET;
					end
				end else if (frm.wr_stb && (frm.addr == ADDR_FMT_PWR)) begin
					q_nxt.fmt = frm.data;
				end
			end
			ST_RESET: begin
				// Held until chip select rises, then clears itself
				if (frm.end_stb) begin
					q_nxt.state = ST_RUN;
				end
			end
			default: begin
				q_nxt.state = ST_RUN;
			end
		endcase
		// Readback: first bit leaves on the fall after the eighth rise
		if (frm.hdr_stb && frm.rw) begin
			q_nxt.rd_sh = rd_val;
			q_nxt.rd_left = RD_BITS;
		end else if (frm.fall_stb && (q_r.rd_left != 4'h0)) begin
			q_nxt.sdo_oe_n = q_r.rd_sh[DATA_W-1];
			q_nxt.rd_sh = {q_r.rd_sh[DATA_W-2:0], 1'b0};
			q_nxt.rd_left = q_r.rd_left - 4'h1;
		end else if (frm.fall_stb) begin
			q_nxt.sdo_oe_n = 1'b1;
		end
		if (frm.end_stb) begin
			q_nxt.rd_left = '0;
			q_nxt.sdo_oe_n = 1'b1;
		end
		// Power state follows the register or the reset in progress
		q_nxt.sleep = q_nxt.fmt[SLEEP_BIT] | (q_nxt.state == ST_RESET);
		q_nxt.nap = q_nxt.sleep ? '0 : q_nxt.fmt[NAP_LSB +: NUM_CH];
		q_nxt.samples = fmt_word;
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			q_r <= REGS_RESET;
		end else begin
			q_r <= q_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Open drain: the pin only ever pulls low
	assign spi_sdo_out = 1'b0;
	assign spi_sdo_oe_n_out = q_r.sdo_oe_n;
	assign fmt_sample_out = q_r.samples;
	assign stabilizer_disable_out = q_r.fmt[STAB_DIS_BIT];
	assign output_scramble_enable_out = q_r.fmt[SCRAMBLE_BIT];
	assign signed_format_select_out = q_r.fmt[SIGNED_BIT];
	assign sleep_out = q_r.sleep;
	assign nap_out = q_r.nap;
	assign soft_reset_busy_out = (q_r.state == ST_RESET);

endmodule // amr_mode_regs

// >>> test/amr_mode_regs_asserts.sv
// Port-level assertions for the mode register bank.
// Assumes one core clock domain; bound to every amr_mode_regs instance.
`timescale 1ns/1ps
module amr_mode_regs_asserts (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic spi_cs_n_in,
	input wire logic spi_sdo_out,
	input wire logic spi_sdo_oe_n_out,
	input wire amr_pkg::amr_chan_words_t conv_sample_in,
	input wire amr_pkg::amr_chan_words_t fmt_sample_out,
	input wire logic stabilizer_disable_out,
	input wire logic output_scramble_enable_out,
	input wire logic signed_format_select_out,
	input wire logic sleep_out,
	input wire logic [amr_pkg::NUM_CH-1:0] nap_out,
	input wire logic soft_reset_busy_out
);
	import amr_pkg::*;
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);
	a_sleep_nap_off: assert property (sleep_out |-> nap_out == 4'h0)
		else $error("nap active in sleep");
	a_reset_sleeps: assert property (soft_reset_busy_out |-> sleep_out)
		else $error("no sleep in soft reset");
	a_reset_clears: assert property (soft_reset_busy_out |->
		!(stabilizer_disable_out | output_scramble_enable_out | signed_format_select_out))
		else $error("controls not cleared");
	a_busy_self_clear: assert property (soft_reset_busy_out && $rose(spi_cs_n_in)
		|-> ##[1:8] !soft_reset_busy_out) else $error("reset bit stuck");
	a_busy_in_frame: assert property ($rose(soft_reset_busy_out) |-> !spi_cs_n_in)
		else $error("reset outside frame");
	a_idle_hold: assert property (spi_cs_n_in [*6] |-> $stable({stabilizer_disable_out,
		output_scramble_enable_out, signed_format_select_out, nap_out}))
		else $error("control change while idle");
	a_oe_idle: assert property (spi_cs_n_in [*6] |-> spi_sdo_oe_n_out)
		else $error("sdo driven while idle");
	a_drain_low: assert property (!spi_sdo_oe_n_out |-> !spi_sdo_out)
		else $error("sdo drives high");
	a_lsb_pass: assert property ($past(resetn_in) |->
		fmt_sample_out[0][0] == $past(conv_sample_in[0][0])) else $error("lsb altered");
	a_signed_msb: assert property ($past(resetn_in) && !$past(output_scramble_enable_out)
		|-> fmt_sample_out[1][13] == ($past(conv_sample_in[1][13]) ^
		$past(signed_format_select_out))) else $error("msb format wrong");
	a_scramble_xor: assert property ($past(resetn_in) |-> fmt_sample_out[2][6] ==
		($past(conv_sample_in[2][6]) ^ ($past(output_scramble_enable_out) &
		$past(conv_sample_in[2][0])))) else $error("randomizer wrong");
	c_busy: cover property ($rose(soft_reset_busy_out));
	c_read: cover property ($fell(spi_sdo_oe_n_out));
	c_sleep: cover property (sleep_out && !soft_reset_busy_out);
endmodule // amr_mode_regs_asserts
bind amr_mode_regs amr_mode_regs_asserts chk_u (.core_clk_in(core_clk_in),
	.resetn_in(resetn_in), .spi_cs_n_in(spi_cs_n_in), .spi_sdo_out(spi_sdo_out),
	.spi_sdo_oe_n_out(spi_sdo_oe_n_out), .conv_sample_in(conv_sample_in),
	.fmt_sample_out(fmt_sample_out), .stabilizer_disable_out(stabilizer_disable_out),
	.output_scramble_enable_out(output_scramble_enable_out),
	.signed_format_select_out(signed_format_select_out), .sleep_out(sleep_out),
	.nap_out(nap_out), .soft_reset_busy_out(soft_reset_busy_out));

// >>> test/amr_spi_host.sv
// Serial configuration host model driving the register port.
// Assumes the caller enters xfer on a core clock falling edge.
`timescale 1ns/1ps
module amr_spi_host #(
	parameter int HALF_NS = 80
) (
	output logic cs_n_out,
	output logic sck_out,
	output logic sdi_out,
	input wire logic sdo_in
);
	initial begin
		cs_n_out = 1'b1;
		sck_out = 1'b0;
		sdi_out = 1'b0;
	end
	// Clock stands low between frames; extra bits only for overrun frames
	task automatic xfer(input logic [23:0] w, input int n, output logic [7:0] rd);
		rd = 8'h00;
		cs_n_out = 1'b0;
		for (int i = 23; i > 23 - n; i--) begin
			sdi_out = w[i];
			#HALF_NS;
			sck_out = 1'b1;
			if (i < 16 && i > 7) rd[i-8] = sdo_in;
			#HALF_NS;
			sck_out = 1'b0;
		end
		#HALF_NS;
		cs_n_out = 1'b1;
		sdi_out = ~sdi_out;
		#(2*HALF_NS);
	endtask
endmodule // amr_spi_host

// >>> test/tb_amr_mode_regs.sv
// Self-checking bench for the mode register bank.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ps
module tb_amr_mode_regs;
	import amr_pkg::*;
	logic core_clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic cs_n, sck, sdi, sdo_oe_n, sdo, stab, scr, sgn, slp, busy;
	logic [3:0] nap;
	amr_chan_words_t conv = '0;
	amr_chan_words_t fmt;
	logic [7:0] d;
	logic [7:0] vals [8] = '{8'h80, 8'h40, 8'h20, 8'h0f, 8'h05, 8'h1f, 8'h6a, 8'h00};
	int num_errors = 0;
	int check_count = 0;
	int cyc = 0;
	int busy_cyc = 0;
	// Open-drain line with its pull-up
	wire sdo_line = sdo_oe_n ? 1'b1 : sdo;
	always #10 core_clk_in = ~core_clk_in;
	// Reset sleep only stands until chip select rises, so count it as it happens
	always @(negedge core_clk_in) begin
		if (busy && slp) begin
			busy_cyc++;
		end
	end
	amr_mode_regs dut_u (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
		.spi_cs_n_in(cs_n), .spi_sck_in(sck), .spi_sdi_in(sdi), .spi_sdo_out(sdo),
		.spi_sdo_oe_n_out(sdo_oe_n), .conv_sample_in(conv), .fmt_sample_out(fmt),
		.stabilizer_disable_out(stab), .output_scramble_enable_out(scr),
		.signed_format_select_out(sgn), .sleep_out(slp), .nap_out(nap),
		.soft_reset_busy_out(busy));
	amr_spi_host host_u (.cs_n_out(cs_n), .sck_out(sck), .sdi_out(sdi), .sdo_in(sdo_line));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		host_u.xfer({1'b0, a, v, 8'h00}, 16, d);
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] v);
		host_u.xfer({1'b1, a, 8'h00, 8'h00}, 16, v);
	endtask
	function automatic logic [13:0] fx(input logic [13:0] s, input logic [7:0] v);
		fx = s ^ {v[5], 13'h0};
		if (v[6]) fx[13:1] = fx[13:1] ^ {13{fx[0]}};
	endfunction
	task automatic ctl(input logic [7:0] v);
		amr_chan_words_t e;
		@(negedge core_clk_in);
		for (int c = 0; c < 4; c++) begin
			conv[c] = {6'h2b, v ^ 8'(c * 37)};
			e[c] = fx(conv[c], v);
		end
		repeat (2) @(negedge core_clk_in);
		chk({stab, scr, sgn, slp, nap}, {v[7:4], v[4] ? 4'h0 : v[3:0]});
		chk(fmt, e);
	endtask
	task automatic end_of_test();
		$display("checks=%0d errors=%0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			end_of_test();
		end
	end
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(negedge core_clk_in);
		resetn_in = 1'b1;
		ctl(8'h00);
		wr(7'h00, 8'h80);
		chk(busy_cyc != 0, 1'b1);
		chk(busy, 1'b0);
		ctl(8'h00);
		foreach (vals[k]) begin
			wr(7'h01, vals[k]);
			ctl(vals[k]);
			rd(7'h01, d);
			chk(d, vals[k]);
			ctl(vals[k]);
		end
		wr(7'h01, 8'he3);
		wr(7'h00, 8'h7f);
		ctl(8'he3);
		rd(7'h00, d);
		chk(d, 8'h00);
		wr(7'h00, 8'hff);
		ctl(8'h00);
		host_u.xfer({1'b0, 7'h01, 8'h21, 8'hff}, 24, d);
		ctl(8'h21);
		end_of_test();
	end
endmodule // tb_amr_mode_regs
